// ---- verilog/pfs_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_top #(
  parameter int SETTLE_CYC = int'(pfs_pkg::SETTLE_CYC),
  parameter int PERIOD_CYC = int'(pfs_pkg::PULSE_PERIOD_CYC),
  parameter int WIDTH_CYC  = int'(pfs_pkg::PULSE_WIDTH_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  cmd_on_i,
  input  wire logic [3:0]  drain_sense_in_i,
  input  wire logic [3:0]  short_sense_i,
  input  wire logic [3:0]  ext_ref_cmp_i,
  input  wire logic        ref_source_select_i,
  input  wire logic        over_batt_i,
  input  wire logic        under_batt_i,
  input  wire logic        cs_b_i,
  input  wire logic        sclk_i,
  output logic [3:0]       gate_drive_out_o,
  output logic             fault_flag_out_o,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic [3:0]       fault_word_o
);
  import pfs_pkg::*;
  // the pulse timer needs an off phase in every period
  if (PERIOD_CYC <= WIDTH_CYC || WIDTH_CYC < 1)
  begin : g_bad_pulse
    $error("pulse period must exceed width");
  end
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sck_s;
    logic [1:0]  ov_s;
    logic [1:0]  uv_s;
    logic        cs_d;
    logic        sck_d;
    logic [31:0] pcnt;
    logic [3:0]  shreg;
    logic [3:0]  fword;
    logic        flag;
    logic        sdo;
    logic        oe;
  } pfs_top_t;
  pfs_top_t    st_reg;
  pfs_top_t    st_next;
  logic [3:0]  lf;
  logic [3:0]  open_cmp;
  logic        batt;
  logic        pulse_on;
  logic        cs_fall;
  logic        sck_fall;
  logic        any_flt;
  //////////////////////////////////////////////////////////////////////////
  // pin inputs arrive asynchronously; two stages each
  logic [3:0] dr_s1;
  logic [3:0] dr_s2;
  logic [3:0] sh_s1;
  logic [3:0] sh_s2;
  logic [3:0] ex_s1;
  logic [3:0] ex_s2;
  logic       rs_s1;
  logic       rs_s2;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      dr_s1 <= 4'hF;
      dr_s2 <= 4'hF;
      sh_s1 <= 4'h0;
      sh_s2 <= 4'h0;
      ex_s1 <= 4'hF;
      ex_s2 <= 4'hF;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
    end
    else
    begin
      dr_s1 <= drain_sense_in_i;
      dr_s2 <= dr_s1;
      sh_s1 <= short_sense_i;
      sh_s2 <= sh_s1;
      ex_s1 <= ext_ref_cmp_i;
      ex_s2 <= ex_s1;
      rs_s1 <= ref_source_select_i;
      rs_s2 <= rs_s1;
    end
  // high input = drain above reference; low = open load
  assign open_cmp = rs_s2 ? ~ex_s2 : ~dr_s2; // R13
  assign batt     = st_reg.ov_s[1] | st_reg.uv_s[1];
  assign pulse_on = st_reg.pcnt < 32'(WIDTH_CYC);
  assign cs_fall  = st_reg.cs_d & ~st_reg.cs_s[1];
  assign sck_fall = st_reg.sck_d & ~st_reg.sck_s[1];
  assign any_flt  = batt | (|lf); // R17
  //////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      pfs_chan #(.SETTLE_CYC(SETTLE_CYC)) u_ch (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .cmd_on_i     (cmd_on_i[g]),
        .batt_fault_i (batt),
        .open_cmp_i   (open_cmp[g]),
        .short_cmp_i  (sh_s2[g]),
        .pulse_on_i   (pulse_on),
        .gate_drive_o (gate_drive_out_o[g]),
        .load_fault_o (lf[g])
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next       = st_reg;
    st_next.cs_s  = {st_reg.cs_s[0], cs_b_i};
    st_next.sck_s = {st_reg.sck_s[0], sclk_i};
    st_next.ov_s  = {st_reg.ov_s[0], over_batt_i};
    st_next.uv_s  = {st_reg.uv_s[0], under_batt_i};
    st_next.cs_d  = st_reg.cs_s[1];
    st_next.sck_d = st_reg.sck_s[1];
    // one shared pulse timer: all shorted channels pulse in step
    st_next.pcnt  = (st_reg.pcnt >= 32'(PERIOD_CYC - 1)) ? 32'h0
                    : st_reg.pcnt + 32'h1;
    // sticky flag: a new fault wins over the select clear
    if (any_flt)
      st_next.flag = 1'b1; // R3 R17 R7 R12
    else if (cs_fall)
      st_next.flag = 1'b0; // R10
    if (cs_fall)
    begin
      // battery faults never enter the word; only live load faults
      st_next.shreg = lf; // R4 R14 R9 R7 R12
      st_next.fword = lf; // R4
      st_next.sdo   = lf[FAULT_MSB]; // R15
      st_next.oe    = 1'b1;
    end
    else if (!st_reg.cs_s[1] && sck_fall)
    begin
      st_next.shreg = {st_reg.shreg[2:0], 1'b0};
      st_next.sdo   = st_reg.shreg[2]; // R15
    end
    else if (st_reg.cs_s[1])
    begin
      st_next.oe    = 1'b0;
      st_next.sdo   = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      st_reg       <= '0;
      st_reg.cs_s  <= 2'h3;
      st_reg.cs_d  <= 1'b1;
      // detectors start at the idle-high level: no false edge
      st_reg.sck_s <= 2'h3;
      st_reg.sck_d <= 1'b1;
      st_reg.fword <= FAULT_WORD_RST;
    end
    else
      st_reg <= st_next;
  assign fault_flag_out_o = st_reg.flag;
  assign sdo_o            = st_reg.sdo;
  assign sdo_oe_o         = st_reg.oe;
  assign fault_word_o     = st_reg.fword;
  //////////////////////////////////////////////////////////////////////////
  // fault flag and battery lockout
  a_flag_follows: assert property ( // R17
    @(posedge clk_i) disable iff (!rst_b_i)
    any_flt |=> fault_flag_out_o)
    else $error("fault present but flag low");
  a_flag_hold: assert property ( // R17
    @(posedge clk_i) disable iff (!rst_b_i)
    fault_flag_out_o && !cs_fall |=> fault_flag_out_o)
    else $error("flag dropped without select");
  a_flag_clear: assert property ( // R10
    @(posedge clk_i) disable iff (!rst_b_i)
    cs_fall && !any_flt |=> !fault_flag_out_o)
    else $error("flag not cleared by select");
  a_batt_flag: assert property ( // R12
    @(posedge clk_i) disable iff (!rst_b_i)
    batt |=> fault_flag_out_o)
    else $error("battery fault not flagged");
  a_batt_drive: assert property ( // R11
    @(posedge clk_i) disable iff (!rst_b_i)
    batt |=> gate_drive_out_o == 4'h0)
    else $error("drives on during battery fault");
  a_batt_mask: assert property ( // R8
    @(posedge clk_i) disable iff (!rst_b_i)
    batt |-> lf == 4'h0)
    else $error("load fault reported in battery fault");
  a_resume_drive: assert property ( // R6
    @(posedge clk_i) disable iff (!rst_b_i)
    !batt && cmd_on_i[0] && !lf[0] ##1 !batt && cmd_on_i[0] && !lf[0]
    |-> gate_drive_out_o[0])
    else $error("drive not resumed");
  //////////////////////////////////////////////////////////////////////////
  // serial readout
  a_word_capture: assert property ( // R14
    @(posedge clk_i) disable iff (!rst_b_i)
    cs_fall |=> fault_word_o == $past(lf))
    else $error("fault word not captured");
  a_word_stable: assert property ( // R9
    @(posedge clk_i) disable iff (!rst_b_i)
    !cs_fall |=> $stable(fault_word_o))
    else $error("fault word changed without select");
  a_word_no_batt: assert property ( // R7
    @(posedge clk_i) disable iff (!rst_b_i)
    cs_fall && batt |=> fault_word_o == 4'h0)
    else $error("battery fault entered fault word");
  a_msb_first: assert property ( // R15
    @(posedge clk_i) disable iff (!rst_b_i)
    cs_fall |=> sdo_o == $past(lf[3]) && sdo_oe_o)
    else $error("msb not presented");
  a_shift_bit: assert property ( // R15
    @(posedge clk_i) disable iff (!rst_b_i)
    !cs_fall && !st_reg.cs_s[1] && sck_fall
    |=> sdo_o == $past(st_reg.shreg[2]))
    else $error("serial bit not shifted");
  a_oe_release: assert property ( // R15
    @(posedge clk_i) disable iff (!rst_b_i)
    st_reg.cs_s[1] |=> !sdo_oe_o && !sdo_o)
    else $error("serial output not released");
  a_sdo_quiet: assert property ( // R15
    @(posedge clk_i) disable iff (!rst_b_i)
    !sdo_oe_o |-> !sdo_o)
    else $error("serial data while released");
  c_cs_fall:  cover property (@(posedge clk_i) cs_fall);
  c_batt:     cover property (@(posedge clk_i) batt && fault_flag_out_o);
  c_loadflt:  cover property (@(posedge clk_i) |lf);
  c_shift:    cover property (@(posedge clk_i) sck_fall && !st_reg.cs_s[1]);
  c_ext_ref:  cover property (@(posedge clk_i) rs_s2 && (|lf));
endmodule : pfs_top
`default_nettype wire

// ---- verilog/pfs_pkg.sv ----
// Operation
// R1: open-load checked only while gate drive off
// R2: 60ms settle after turn-off before open-load check
// R3: settled low drain sense raises fault flag
// R4: four-bit fault word, one bit per channel
// R5: overvoltage forces all gate drives off
// R6: drives resume automatically after overvoltage clears
// R7: overvoltage on flag only, not fault word
// R8: battery fault masks load-fault reporting
// R9: battery fault gone before select not captured
// R10: select falling clears flag unless faults remain
// R11: undervoltage holds drives off, resumes after
// R12: undervoltage on flag only, not fault word
// R13: reference select picks internal or external compare
// R14: fault word captured on select falling only
// R15: msb out after select falls, rest on sclk fall
// R16: shorted load puts drive into low duty pulsing
// R17: flag active while any fault uncleared
`default_nettype none
package pfs_pkg;
  localparam int          NUM_CH         = 4;
  localparam int          CLK_MHZ        = 250;
  localparam longint      SETTLE_TIME_MS = 60;
  localparam longint      SETTLE_CYC     = SETTLE_TIME_MS * 1000 * CLK_MHZ;
  localparam longint      PULSE_PERIOD_US = 1000;
  localparam longint      PULSE_WIDTH_US  = 20;
  localparam longint      PULSE_PERIOD_CYC = PULSE_PERIOD_US * CLK_MHZ;
  localparam longint      PULSE_WIDTH_CYC  = PULSE_WIDTH_US * CLK_MHZ;
  localparam logic [3:0]  FAULT_WORD_RST = 4'h0;
  localparam int          FAULT_MSB      = 3;
endpackage : pfs_pkg
`default_nettype wire

// ---- verilog/pfs_chan.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_chan #(
  parameter int SETTLE_CYC = 15000000
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic cmd_on_i,
  input  wire logic batt_fault_i,
  input  wire logic open_cmp_i,
  input  wire logic short_cmp_i,
  input  wire logic pulse_on_i,
  output logic      gate_drive_o,
  output logic      load_fault_o
);
  import pfs_pkg::*;
  if (SETTLE_CYC < 1)
  begin : g_bad_settle
    $error("settle count must be positive");
  end
  typedef struct packed {
    logic [31:0] cnt;
    logic        settled;
    logic        short_flt;
    logic        open_flt;
    logic        drv;
  } pfs_ch_t;
  pfs_ch_t st_reg;
  pfs_ch_t st_next;
  logic    eff_on;
  always_comb
  begin
    st_next = st_reg;
    eff_on  = cmd_on_i & ~batt_fault_i; // R5 R11 R6
    if (!cmd_on_i)
      st_next.short_flt = 1'b0;
    else if (short_cmp_i & ~batt_fault_i & eff_on)
      st_next.short_flt = 1'b1;
    st_next.drv = eff_on & (~st_reg.short_flt | pulse_on_i); // R16
    if (st_reg.drv | eff_on)
    begin
      st_next.cnt     = 32'h0; // R2
      st_next.settled = 1'b0;
    end
    else if (!st_reg.settled)
    begin
      if (st_reg.cnt >= 32'(SETTLE_CYC - 1))
        st_next.settled = 1'b1;
      else
        st_next.cnt = st_reg.cnt + 32'h1;
    end
    // open load only judged with drive off and settled
    st_next.open_flt = st_reg.settled & ~st_reg.drv & ~eff_on
                       & open_cmp_i & ~batt_fault_i; // R1 R3 R8
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  assign gate_drive_o = st_reg.drv;
  assign load_fault_o = (st_reg.open_flt | st_reg.short_flt)
                        & ~batt_fault_i; // R8
  a_open_off_only: assert property ( // R1
    @(posedge clk_i) disable iff (!rst_b_i)
    st_reg.open_flt |-> !st_reg.drv)
    else $error("open fault while driving");
  a_batt_off: assert property ( // R5
    @(posedge clk_i) disable iff (!rst_b_i)
    batt_fault_i |=> !st_reg.drv)
    else $error("drive on during battery fault");
endmodule : pfs_chan
`default_nettype wire

// ---- dv/pfs_mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_mcu_model (
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_b_o,
  output logic      sclk_o
);
  logic line;
  // a released line reads as the inverse of sdo_i, which is held low then, so it reads high
  assign line = sdo_oe_i ? sdo_i : ~sdo_i;
  // link clock idles high and toggles only inside a frame
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // half a link period between moves leaves the synchronisers ample margin
  task automatic read_word(output logic [3:0] w);
    cs_b_o = 1'b0;
    #62.5;
    w[3] = line;
    for (int i = 2; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      #62.5;
      w[i] = line;
      sclk_o = 1'b1;
      #62.5;
    end
    cs_b_o = 1'b1;
    #62.5;
  endtask : read_word
endmodule : pfs_mcu_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pfs_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic [3:0] cmd, drain, shrt, ext, gate, word;
  logic       rsel, ovr, und, cs_b, sclk, flag, sdo, oe;
  int         failures = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] cnt;
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  pfs_top #(.SETTLE_CYC(20), .PERIOD_CYC(20), .WIDTH_CYC(4)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_on_i(cmd),
    .drain_sense_in_i(drain), .short_sense_i(shrt), .ext_ref_cmp_i(ext),
    .ref_source_select_i(rsel), .over_batt_i(ovr), .under_batt_i(und),
    .cs_b_i(cs_b), .sclk_i(sclk), .gate_drive_out_o(gate),
    .fault_flag_out_o(flag), .sdo_o(sdo), .sdo_oe_o(oe),
    .fault_word_o(word));
  pfs_mcu_model u_mcu (.sdo_i(sdo), .sdo_oe_i(oe), .cs_b_o(cs_b),
    .sclk_o(sclk));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask : clks
  task automatic rd(input logic [3:0] exp);
    logic [3:0] w;
    u_mcu.read_word(w);
    check(w, exp);
    check(word, exp);
    check({3'h0, oe}, 4'h0);
    clks(4);
  endtask : rd
  // restore healthy loads, then a read must leave the flag down
  task automatic clr();
    drain = 4'hF;
    ext = 4'hF;
    clks(5);
    rd(4'h0);
    check({3'h0, flag}, 4'h0);
  endtask : clr
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    {cmd, drain, shrt, ext} = {4'hF, 4'hF, 4'h0, 4'hF};
    {rsel, ovr, und} = 3'h0;
    clks(12);
    check(gate, 4'h0);
    check({3'h0, flag}, 4'h0);
    rst_b_i = 1'b1;
    clks(40);
    check(gate, 4'hF);
    drain = 4'h0;
    clks(40);
    check({3'h0, flag}, 4'h0);
    cmd = 4'hB;
    clks(10);
    check({3'h0, flag}, 4'h0);
    clks(25);
    check({3'h0, flag}, 4'h1);
    rd(4'h4);
    check({3'h0, flag}, 4'h1);
    clr();
    // external reference path: internal compare says open, external not
    {cmd, rsel, drain} = {4'h0, 1'b1, 4'h0};
    clks(40);
    check({3'h0, flag}, 4'h0);
    ext = 4'hE;
    clks(40);
    check({3'h0, flag}, 4'h1);
    rd(4'h1);
    rsel = 1'b0;
    clr();
    for (int i = 0; i < 2; i++)
    begin
      cmd = 4'hF;
      clks(40);
      {und, ovr} = (i == 0) ? 2'b01 : 2'b10;
      clks(6);
      check(gate, 4'h0);
      check({3'h0, flag}, 4'h1);
      drain = 4'h0;
      clks(40);
      rd(4'h0);
      check({3'h0, flag}, 4'h1);
      drain = 4'hF;
      clks(2);
      {und, ovr} = 2'b00;
      clks(6);
      check(gate, 4'hF);
      rd(4'h0);
      check({3'h0, flag}, 4'h0);
    end
    {cmd, shrt} = {4'h2, 4'h2};
    clks(10);
    cnt = 8'h00;
    repeat (40)
    begin
      @(negedge clk_i);
      cnt = cnt + {7'h00, gate[1]};
    end
    check(cnt[3:0], 4'h8);
    check(cnt[7:4], 4'h0);
    check({3'h0, flag}, 4'h1);
    rd(4'h2);
    {cmd, shrt} = {4'h0, 4'h0};
    clr();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
